/* logic/dfp_core.sv */
`timescale 1ns/10ps
module dfp_core (
   input wire logic sys_clk_i, // System clock, 20 MHz.
   input wire logic resetn_i, // Asynchronous reset, active low.
   input wire logic cs_n_i, // Serial chip select, active low.
   input wire logic sclk_i, // Serial clock.
   input wire logic sdi_i, // Serial data in.
   output logic sdo_o, // Serial data out.
   output logic sdo_oe_n_o, // Serial data out enable, low while driven.
   input wire logic [5:0] pw_set_i, // Stage above prewarning set threshold.
   input wire logic [5:0] pw_clr_i, // Stage below prewarning clear threshold.
   input wire logic [5:0] ts_hot_i, // Stage above thermal switch-off threshold.
   input wire logic [5:0] ts_cool_i, // Stage below thermal switch-on threshold.
   input wire logic [5:0] oc_i, // Stage above overcurrent shutdown threshold.
   output logic [5:0] out_en_o, // Output stage enables.
   output logic [15:0] ctrl_o, // Current control word.
   output logic [15:0] status_o // Current status word.
);

   // Pin synchronisers and edge history.
   logic [2:0] cs_sync_r, cs_sync_nxt;
   logic [2:0] sclk_sync_r, sclk_sync_nxt;
   logic [1:0] sdi_sync_r, sdi_sync_nxt;

   always_comb begin
      cs_sync_nxt = {cs_sync_r[1:0], cs_n_i};
      sclk_sync_nxt = {sclk_sync_r[1:0], sclk_i};
      sdi_sync_nxt = {sdi_sync_r[0], sdi_i};
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cs_sync_r <= 3'h7;
         sclk_sync_r <= 3'h0;
         sdi_sync_r <= 2'h0;
      end else begin
         cs_sync_r <= cs_sync_nxt;
         sclk_sync_r <= sclk_sync_nxt;
         sdi_sync_r <= sdi_sync_nxt;
      end
   end

   logic cs_fall, cs_rise, sclk_rise, sclk_fall, sdi_s;
   assign cs_fall = cs_sync_r[2] & ~cs_sync_r[1];
   assign cs_rise = ~cs_sync_r[2] & cs_sync_r[1];
   assign sclk_rise = ~sclk_sync_r[2] & sclk_sync_r[1];
   assign sclk_fall = sclk_sync_r[2] & ~sclk_sync_r[1];
   assign sdi_s = sdi_sync_r[1];

   // Serial link and control word.
   dfp_pkg::dfp_link_st_t lk_st_r, lk_st_nxt;
   logic [15:0] sh_r, sh_nxt;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic got_word_r, got_word_nxt;
   logic sdo_r, sdo_nxt;
   logic rst_req_pulse_r, rst_req_pulse_nxt;
   dfp_pkg::dfp_ctrl_t ctrl_r, ctrl_nxt;
   dfp_pkg::dfp_status_t status;
   logic commit;

   // Only whole frames are taken; daisy-chained multiples keep the last word.
   assign commit = cs_rise & got_word_r & (bit_cnt_r == 4'h0);

   always_comb begin
      lk_st_nxt = lk_st_r;
      sh_nxt = sh_r;
      bit_cnt_nxt = bit_cnt_r;
      got_word_nxt = got_word_r;
      sdo_nxt = sdo_r;
      ctrl_nxt = ctrl_r;
      rst_req_pulse_nxt = 1'b0;
      unique case (lk_st_r)
         dfp_pkg::LK_IDLE: begin
            if (cs_fall) begin
               lk_st_nxt = dfp_pkg::LK_SHIFT;
               sh_nxt = status;
               sdo_nxt = status.temp_prewarn_flag;
               bit_cnt_nxt = 4'h0;
               got_word_nxt = 1'b0;
            end
         end
         dfp_pkg::LK_SHIFT: begin
            if (cs_rise) begin
               lk_st_nxt = dfp_pkg::LK_IDLE;
               if (commit) begin
                  ctrl_nxt = sh_r;
                  rst_req_pulse_nxt = sh_r[dfp_pkg::CTRL_STAT_RST_BIT];
               end
            end else if (sclk_rise) begin
               sh_nxt = {sdi_s, sh_r[15:1]};
               bit_cnt_nxt = bit_cnt_r + 4'h1;
               if (bit_cnt_r == 4'hf) begin
                  got_word_nxt = 1'b1;
               end
            end else if (sclk_fall) begin
               sdo_nxt = sh_r[0];
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lk_st_r <= dfp_pkg::LK_IDLE;
         sh_r <= 16'h0000;
         bit_cnt_r <= 4'h0;
         got_word_r <= 1'b0;
         sdo_r <= 1'b0;
         rst_req_pulse_r <= 1'b0;
         ctrl_r <= dfp_pkg::CTRL_RESET;
      end else begin
         lk_st_r <= lk_st_nxt;
         sh_r <= sh_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         got_word_r <= got_word_nxt;
         sdo_r <= sdo_nxt;
         rst_req_pulse_r <= rst_req_pulse_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // Protection state.
   logic prewarn_r, prewarn_nxt;
   logic overload_r, overload_nxt;
   logic [5:0] fault_r, fault_nxt;
   logic [5:0] out_en_r, out_en_nxt;
   logic [dfp_pkg::SD_CNT_W-1:0] oc_cnt_r [dfp_pkg::NUM_CH];
   logic [dfp_pkg::SD_CNT_W-1:0] oc_cnt_nxt [dfp_pkg::NUM_CH];
   logic [5:0] oc_trip, fault_set;

   always_comb begin
      for (int k = 0; k < dfp_pkg::NUM_CH; k++) begin
         if (ctrl_r.ocs && oc_i[k] && !fault_r[k]) begin
            oc_cnt_nxt[k] = (oc_cnt_r[k] == dfp_pkg::SD_LAST) ? oc_cnt_r[k] :
                            oc_cnt_r[k] + 1'b1;
         end else begin
            oc_cnt_nxt[k] = '0;
         end
         oc_trip[k] = ctrl_r.ocs & oc_i[k] & ~fault_r[k] &
                      (oc_cnt_r[k] == dfp_pkg::SD_LAST);
      end
      fault_set = ts_hot_i | oc_trip;
      // clear only on request when cool
      fault_nxt = fault_set | (fault_r & ~({6{rst_req_pulse_r}} & ts_cool_i));
      overload_nxt = (|fault_set) | (overload_r & ~rst_req_pulse_r);
      if (|pw_set_i) begin
         prewarn_nxt = 1'b1;
      end else if (&pw_clr_i) begin
         prewarn_nxt = 1'b0;
      end else begin
         prewarn_nxt = prewarn_r;
      end
      out_en_nxt = {6{ctrl_r.si}} & ctrl_r.ch & ~fault_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prewarn_r <= 1'b0;
         overload_r <= 1'b0;
         fault_r <= 6'h00;
         out_en_r <= 6'h00;
         for (int k = 0; k < dfp_pkg::NUM_CH; k++) begin
            oc_cnt_r[k] <= '0;
         end
      end else begin
         prewarn_r <= prewarn_nxt;
         overload_r <= overload_nxt;
         fault_r <= fault_nxt;
         out_en_r <= out_en_nxt;
         for (int k = 0; k < dfp_pkg::NUM_CH; k++) begin
            oc_cnt_r[k] <= oc_cnt_nxt[k];
         end
      end
   end

   always_comb begin
      status = '0;
      status.temp_prewarn_flag = prewarn_r;
      status.ch = out_en_r;
      status.overload_flag = overload_r;
      status.inhibit_status = ~ctrl_r.si;
   end

   assign sdo_o = sdo_r;
   assign sdo_oe_n_o = cs_sync_r[1];
   assign out_en_o = out_en_r;
   assign ctrl_o = ctrl_r;
   assign status_o = status;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   prewarn_set_a: assert property (|pw_set_i |=> prewarn_r)
      else $error("prewarning flag not set");
   prewarn_clear_a: assert property ((&pw_clr_i && !(|pw_set_i)) |=> !prewarn_r)
      else $error("prewarning flag not cleared");
   sdo_early_a: assert property (cs_fall && lk_st_r == dfp_pkg::LK_IDLE |=>
      sdo_o == $past(prewarn_r) && !sdo_oe_n_o)
      else $error("prewarning not on serial output after select");
   abort_keep_a: assert property (cs_rise && !commit |=>
      ctrl_r == $past(ctrl_r) && !rst_req_pulse_r)
      else $error("aborted frame changed control");
   tsd_off_a: assert property (|ts_hot_i |=>
      (out_en_r & $past(ts_hot_i)) == 6'h00 && (status.ch & $past(ts_hot_i)) == 6'h00)
      else $error("hot stage still enabled");
   tsd_overload_a: assert property (|ts_hot_i |=> overload_r)
      else $error("thermal shutdown missed overload");
   hot_hold_a: assert property (fault_r[1] && !ts_cool_i[1] |=> fault_r[1])
      else $error("hot stage re-enabled");
   oc_delay_a: assert property (ctrl_r.ocs && !fault_r[3] && !ts_hot_i[3] && oc_i[3]
      && oc_cnt_r[3] == '0 ##1 (ctrl_r.ocs && oc_i[3] && !ts_hot_i[3])[*8]
      |-> !fault_r[3])
      else $error("overcurrent tripped too early");
   oc_off_a: assert property (!ctrl_r.ocs && ts_hot_i == 6'h00 && !rst_req_pulse_r
      && !overload_r |=> !overload_r)
      else $error("overload set while unarmed");
   rst_req_clear_a: assert property (rst_req_pulse_r && ts_hot_i == 6'h00
      && oc_trip == 6'h00 |=> !overload_r && (fault_r & $past(ts_cool_i)) == 6'h00)
      else $error("status reset did not clear");
   inhibit_a: assert property (!ctrl_r.si |->
      status.inhibit_status ##1 out_en_r == 6'h00)
      else $error("stage on in standby");
   resume_a: assert property (ctrl_r.si && fault_nxt == 6'h00 |=>
      out_en_r == $past(ctrl_r.ch))
      else $error("stages not following control");

   abort_c: cover property (cs_rise && !commit && lk_st_r == dfp_pkg::LK_SHIFT);
   commit_c: cover property (commit);
   oc_trip_c: cover property (oc_trip != 6'h00);
   tsd_c: cover property (ts_hot_i != 6'h00 && out_en_r != 6'h00);

endmodule : dfp_core

/* logic/dfp_pkg.sv */
package dfp_pkg;
   // Number of output stages and the serial frame length.
   localparam int NUM_CH = 6;
   localparam int FRAME_BITS = 16;

   // Control word field positions.
   localparam int CTRL_STAT_RST_BIT = 0;
   localparam int CTRL_CH_LSB = 1;
   localparam int CTRL_OLD_BIT = 13;
   localparam int CTRL_OCS_BIT = 14;
   localparam int CTRL_SI_BIT = 15;
   localparam logic [15:0] CTRL_RESET = 16'he000;

   // Status word field positions.
   localparam int ST_PREWARN_BIT = 0;
   localparam int ST_CH_LSB = 1;
   localparam int ST_OVERLOAD_BIT = 13;
   localparam int ST_INHIBIT_BIT = 14;
   localparam int ST_PSF_BIT = 15;

   // Timing.
   localparam int CLK_PERIOD_NS = 50;
   localparam int SD_DELAY_NS = 1000;
   localparam int SD_CYCLES = (SD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SD_CNT_W = 8;
   localparam logic [SD_CNT_W-1:0] SD_LAST = SD_CNT_W'(SD_CYCLES - 1);

   typedef struct packed {
      logic si;
      logic ocs;
      logic old;
      logic [5:0] pwm_sel;
      logic [5:0] ch;
      logic status_reset_request;
   } dfp_ctrl_t;

   typedef struct packed {
      logic psf;
      logic inhibit_status;
      logic overload_flag;
      logic [5:0] unused;
      logic [5:0] ch;
      logic temp_prewarn_flag;
   } dfp_status_t;

   typedef enum logic [0:0] {LK_IDLE, LK_SHIFT} dfp_link_st_t;
endpackage : dfp_pkg

/* verif/dfp_core_tb.sv */
`timescale 1ns/10ps
module dfp_core_tb;
   logic sys_clk_i, resetn_i, cs_n, sclk, sdi, sdo, sdo_oe_n, pw_bit, oe_n;
   logic [5:0] pw_set, pw_clr, ts_hot, ts_cool, oc, out_en;
   logic [15:0] ctrl, status, rd;
   int fail_count, samples_checked;

   dfp_core DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .pw_set_i(pw_set), .pw_clr_i(pw_clr),
      .ts_hot_i(ts_hot), .ts_cool_i(ts_cool), .oc_i(oc), .out_en_o(out_en), .ctrl_o(ctrl),
      .status_o(status));
   dfp_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
      .sdo_oe_n_i(sdo_oe_n));

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : cyc
   task automatic wr(input logic [15:0] w);
      host.xfer(w, rd);
      cyc(10);
   endtask : wr
   task automatic wait_en(input logic [5:0] exp);
      int k;
      k = 0;
      while (out_en !== exp && k < 40) begin
         cyc(1);
         k++;
      end
      chk("out_en", {10'h000, exp}, {10'h000, out_en});
      if (out_en !== exp) close_out();
   endtask : wait_en

   initial begin
      fail_count = 0;
      samples_checked = 0;
      resetn_i = 1'b0;
      pw_set = 6'h00;
      pw_clr = 6'h3f;
      ts_hot = 6'h00;
      ts_cool = 6'h3f;
      oc = 6'h00;
      cyc(16);
      chk("ctrl reset", dfp_pkg::CTRL_RESET, ctrl);
      chk("status reset", 16'h0000, status);
      resetn_i = 1'b1;
      cyc(4);
      pw_clr = 6'h3b;
      pw_set = 6'h04;
      cyc(3);
      chk("prewarn set", 16'h0001, status);
      pw_set = 6'h00;
      host.peek(pw_bit, oe_n);
      chk("early flag", 16'h0001, {15'h0000, pw_bit});
      chk("early oe_n", 16'h0000, {15'h0000, oe_n});
      cyc(10);
      chk("ctrl kept", 16'he000, ctrl);
      chk("prewarn held", 16'h0001, status);
      pw_clr = 6'h3f;
      cyc(3);
      chk("prewarn clear", 16'h0000, status);
      wr(16'he07e);
      wait_en(6'h3f);
      host.xfer(16'he07e, rd);
      chk("serial status", 16'h007e, rd);
      ts_hot = 6'h02;
      ts_cool = 6'h3d;
      cyc(3);
      chk("thermal off", 16'h207a, status);
      ts_hot = 6'h00;
      wr(16'he07f);
      chk("still off", 16'h007a, status);
      ts_cool = 6'h3f;
      wr(16'he07f);
      chk("re-enabled", 16'h007e, status);
      oc = 6'h08;
      cyc(15);
      chk("oc delay", 16'h007e, status);
      cyc(10);
      chk("oc trip", 16'h206e, status);
      oc = 6'h00;
      wr(16'he07f);
      chk("oc cleared", 16'h007e, status);
      wr(16'ha07e);
      oc = 6'h10;
      cyc(40);
      chk("oc ignored", 16'h007e, status);
      oc = 6'h00;
      wr(16'h207e);
      chk("standby", 16'h4000, status);
      host.xfer(16'h207e, rd);
      chk("standby read", 16'h4000, rd);
      wr(16'he07e);
      wait_en(6'h3f);
      chk("awake", 16'h007e, status);
      resetn_i = 1'b0;
      cyc(2);
      chk("ctrl re-reset", dfp_pkg::CTRL_RESET, ctrl);
      chk("status re-reset", 16'h0000, status);
      resetn_i = 1'b1;
      cyc(4);
      close_out();
   end
endmodule : dfp_core_tb

/* verif/dfp_host_model.sv */
`timescale 1ns/10ps
module dfp_host_model (
   output logic cs_n_o, // Chip select, active low.
   output logic sclk_o, // Serial clock, idle low.
   output logic sdi_o, // Serial data to the device.
   input wire logic sdo_i, // Serial data from the device.
   input wire logic sdo_oe_n_i // Device output enable, low while driven.
);
   localparam time HALF = 200ns;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
      #13;
      cs_n_o = 1'b0;
      sdi_o = wr[0];
      #HALF;
      for (int i = 0; i < 16; i++) begin
         rd[i] = sdo_i;
         sclk_o = 1'b1;
         #HALF;
         sclk_o = 1'b0;
         if (i < 15) sdi_o = wr[i+1];
         #HALF;
      end
      cs_n_o = 1'b1;
      // The released line must not keep its last value.
      sdi_o = ~sdi_o;
      #HALF;
   endtask : xfer
   task automatic peek(output logic flag, output logic oe_n);
      #13;
      cs_n_o = 1'b0;
      #HALF;
      flag = sdo_i;
      oe_n = sdo_oe_n_i;
      cs_n_o = 1'b1;
      #HALF;
   endtask : peek
endmodule : dfp_host_model
